// ---- uhid_consts.svh ----
`ifndef UHID_CONSTS_SVH
`define UHID_CONSTS_SVH

// Register byte offsets
`define UHID_OFS_STATUS 12'h000
`define UHID_OFS_ENABLE 12'h004
`define UHID_OFS_DISABLE 12'h008
`define UHID_OFS_SWRESET 12'h00C

// Field positions in the enable, disable and status layout
`define UHID_BIT_MASTER 31
`define UHID_BIT_PORT_CHANGE 6
`define UHID_BIT_FRAME_WRAP 5
`define UHID_BIT_FATAL_FAULT 4
`define UHID_BIT_RESUME 3
`define UHID_BIT_FRAME_BEGIN 2
`define UHID_BIT_OVERRUN 0
`define UHID_BIT_SWRESET 0

// Implemented bits and reset values
`define UHID_SRC_MASK 32'h0000_007D
`define UHID_ENABLE_MASK 32'h8000_007D
`define UHID_ENABLE_RESET 32'h8000_0000
`define UHID_STATUS_RESET 32'h0000_0000
`define UHID_ZERO_WORD 32'h0000_0000

// AHB encodings
`define UHID_HSIZE_WORD 3'h2
`define UHID_HRESP_OKAY 1'h0
`define UHID_ADDR_DECODE_BITS 12

`endif

// ---- uhid_pkg.sv ----
package uhid_pkg;

  typedef logic [31:0] uhid_word_t;

  // One-hot register select for the data phase
  typedef enum logic [4:0] {
    UHID_SEL_NONE = 5'b00001,
    UHID_SEL_STATUS = 5'b00010,
    UHID_SEL_ENABLE = 5'b00100,
    UHID_SEL_DISABLE = 5'b01000,
    UHID_SEL_SWRESET = 5'b10000
  } uhid_sel_t;

endpackage : uhid_pkg

// ---- uhid_sticky_bank.sv ----
`timescale 1ns/1ps
`include "uhid_consts.svh"

module uhid_sticky_bank #(
  parameter int WIDTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] keep_mask,
  input wire logic [WIDTH-1:0] set_vec,
  input wire logic [WIDTH-1:0] clr_vec,
  input wire logic clr_all,
  output logic [WIDTH-1:0] flags
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
      logic next_flag;
      // Set beats clear so an event in the clearing cycle survives
      assign next_flag = keep_mask[i] &
        (set_vec[i] | (flags[i] & ~clr_vec[i] & ~clr_all));
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flags[i] <= 1'b0;
        end else begin
          flags[i] <= next_flag;
        end
      end
    end
  endgenerate

endmodule : uhid_sticky_bank

// ---- uhid_irq_disable.sv ----
`timescale 1ns/1ps
`include "uhid_consts.svh"


module uhid_irq_disable (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire uhid_pkg::uhid_word_t hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output uhid_pkg::uhid_word_t hrdata,
  input wire logic evt_port_change,
  input wire logic evt_frame_wrap,
  input wire logic evt_fatal_fault,
  input wire logic evt_resume,
  input wire logic evt_frame_begin,
  input wire logic evt_sched_overrun,
  output logic irq,
  output logic master_interrupt_switch
);

  import uhid_pkg::*;

  // Event sources sharing the enable, disable and status layout
  localparam int NUM_SRC = 6;

  // Address phase decode
  function automatic uhid_sel_t addr_to_sel(
    input logic [`UHID_ADDR_DECODE_BITS-1:0] ofs
  );
    uhid_sel_t sel;
    sel = UHID_SEL_NONE;
    if (ofs == `UHID_OFS_STATUS) begin
      sel = UHID_SEL_STATUS;
    end else if (ofs == `UHID_OFS_ENABLE) begin
      sel = UHID_SEL_ENABLE;
    end else if (ofs == `UHID_OFS_DISABLE) begin
      sel = UHID_SEL_DISABLE;
    end else if (ofs == `UHID_OFS_SWRESET) begin
      sel = UHID_SEL_SWRESET;
    end
    return sel;
  endfunction : addr_to_sel

  // Register position of each event source, in event port order
  function automatic int src_pos(input int idx);
    int pos;
    pos = `UHID_BIT_OVERRUN;
    if (idx == 1) begin
      pos = `UHID_BIT_FRAME_BEGIN;
    end else if (idx == 2) begin
      pos = `UHID_BIT_RESUME;
    end else if (idx == 3) begin
      pos = `UHID_BIT_FATAL_FAULT;
    end else if (idx == 4) begin
      pos = `UHID_BIT_FRAME_WRAP;
    end else if (idx == 5) begin
      pos = `UHID_BIT_PORT_CHANGE;
    end
    return pos;
  endfunction : src_pos

  // Spreads event-ordered bits onto their register positions
  function automatic uhid_word_t spread_src(input logic [NUM_SRC-1:0] v);
    uhid_word_t word;
    word = `UHID_ZERO_WORD;
    for (int idx = 0; idx < NUM_SRC; idx++) begin
      word[src_pos(idx)] = v[idx];
    end
    return word;
  endfunction : spread_src

  // Bus state
  logic wr_pend;
  uhid_sel_t wr_sel;

  // Block state
  uhid_word_t int_enable;
  uhid_word_t int_status;

  // Address phase
  wire logic addr_valid;
  wire logic addr_word;
  wire logic addr_wr;
  wire logic addr_rd;
  wire uhid_sel_t addr_sel;

  assign addr_valid = hsel & htrans[1] & hready;
  // Narrow writes are answered OKAY but not stored; narrow reads are decoded and return data
  assign addr_word = (hsize == `UHID_HSIZE_WORD);
  assign addr_wr = addr_valid & hwrite & addr_word;
  assign addr_rd = addr_valid & ~hwrite;
  assign addr_sel =
    addr_to_sel(haddr[`UHID_ADDR_DECODE_BITS-1:0]);

  // Data phase write strobes
  wire logic wr_status;
  wire logic wr_enable;
  wire logic wr_disable;
  wire logic wr_swreset;

  assign wr_status = wr_pend & (wr_sel == UHID_SEL_STATUS);
  assign wr_enable = wr_pend & (wr_sel == UHID_SEL_ENABLE);
  assign wr_disable = wr_pend & (wr_sel == UHID_SEL_DISABLE);
  assign wr_swreset = wr_pend & (wr_sel == UHID_SEL_SWRESET);

  // Software reset is a self-clearing strobe, it reads back as zero
  wire logic soft_reset;
  assign soft_reset = wr_swreset & hwdata[`UHID_BIT_SWRESET];

  // Reserved positions never store, so stray ones are dropped
  wire uhid_word_t wr_ones;
  assign wr_ones = hwdata & `UHID_ENABLE_MASK;

  // Enable write sets bits, disable write clears them; zeros do nothing
  wire uhid_word_t set_bits;
  wire uhid_word_t clr_bits;
  assign set_bits = wr_enable ? wr_ones : `UHID_ZERO_WORD;
  // Zero in any position leaves that enable untouched
  assign clr_bits = wr_disable ? wr_ones : `UHID_ZERO_WORD;

  wire logic clr_master;
  wire logic clr_port_change;
  wire logic clr_frame_wrap;
  wire logic clr_fatal_fault;
  wire logic clr_resume;
  wire logic clr_frame_begin;
  wire logic clr_overrun;

  assign clr_master = clr_bits[`UHID_BIT_MASTER];
  assign clr_port_change = clr_bits[`UHID_BIT_PORT_CHANGE];
  assign clr_frame_wrap = clr_bits[`UHID_BIT_FRAME_WRAP];
  assign clr_fatal_fault = clr_bits[`UHID_BIT_FATAL_FAULT];
  assign clr_resume = clr_bits[`UHID_BIT_RESUME];
  assign clr_frame_begin = clr_bits[`UHID_BIT_FRAME_BEGIN];
  assign clr_overrun = clr_bits[`UHID_BIT_OVERRUN];

  wire uhid_word_t clr_vec;
  assign clr_vec = {clr_master, 24'h00_0000, clr_port_change,
    clr_frame_wrap, clr_fatal_fault, clr_resume, clr_frame_begin,
    1'b0, clr_overrun};

  // Disable wins if both land together; only one write per cycle anyway
  wire uhid_word_t next_int_enable;
  assign next_int_enable = soft_reset ? `UHID_ENABLE_RESET :
    ((int_enable | set_bits) & ~clr_vec);

  // Event inputs come from controller logic on hclk, no synchroniser
  wire logic [NUM_SRC-1:0] evt_src;
  wire uhid_word_t evt_vec;
  assign evt_src = {evt_port_change, evt_frame_wrap, evt_fatal_fault,
    evt_resume, evt_frame_begin, evt_sched_overrun};
  assign evt_vec = spread_src(evt_src);

  wire uhid_word_t status_clr;
  assign status_clr = wr_status ? wr_ones : `UHID_ZERO_WORD;

  // Events latch whatever the enable state is
  uhid_sticky_bank #(
    .WIDTH(32)
  ) u_status (
    .hclk(hclk),
    .hresetn(hresetn),
    .keep_mask(`UHID_SRC_MASK),
    .set_vec(evt_vec),
    .clr_vec(status_clr),
    .clr_all(soft_reset),
    .flags(int_status)
  );

  // Next status for read-after-write in back to back transfers
  wire uhid_word_t next_int_status;
  assign next_int_status = `UHID_SRC_MASK & (evt_vec |
    (int_status & ~status_clr & {32{~soft_reset}}));

  // Per-source view of the next state for the interrupt term
  wire logic [NUM_SRC-1:0] src_status;
  wire logic [NUM_SRC-1:0] src_enable;
  wire logic [NUM_SRC-1:0] src_fire;

  genvar s;
  generate
    for (s = 0; s < NUM_SRC; s = s + 1) begin : g_src
      localparam int POS = src_pos(s);
      assign src_status[s] = next_int_status[POS];
      assign src_enable[s] = next_int_enable[POS];
      // Disabling gates only the output, the flag keeps recording
      assign src_fire[s] = src_status[s] & src_enable[s];
    end
  endgenerate

  // Output gating by master switch and per-source enable
  wire logic next_irq;
  assign next_irq = next_int_enable[`UHID_BIT_MASTER] &
    (|src_fire);

  // Read data built from next values so a read right after a write
  // sees the new contents
  wire logic rd_status;
  wire logic rd_enable;
  wire uhid_word_t next_hrdata;
  assign rd_status = addr_rd & (addr_sel == UHID_SEL_STATUS);
  // The disable register reads back the enable state it clears
  assign rd_enable = addr_rd & ((addr_sel == UHID_SEL_ENABLE) |
    (addr_sel == UHID_SEL_DISABLE));
  assign next_hrdata = rd_status ? next_int_status :
    rd_enable ? next_int_enable : `UHID_ZERO_WORD;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_sel <= UHID_SEL_NONE;
    end else begin
      wr_pend <= addr_wr;
      wr_sel <= addr_wr ? addr_sel : UHID_SEL_NONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_enable <= `UHID_ENABLE_RESET;
    end else begin
      int_enable <= next_int_enable;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `UHID_ZERO_WORD;
    end else begin
      hrdata <= next_hrdata;
    end
  end

  // Zero wait and always OKAY: no register access ever needs a stall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= `UHID_HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= `UHID_HRESP_OKAY;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  // Master state as a level for the rest of the controller
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      master_interrupt_switch <= 1'b1;
    end else begin
      master_interrupt_switch <= next_int_enable[`UHID_BIT_MASTER];
    end
  end

endmodule : uhid_irq_disable

// ---- uhid_irq_disable_asserts.sv ----
`timescale 1ns/1ps
`include "uhid_consts.svh"
module uhid_irq_disable_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire uhid_pkg::uhid_word_t hwdata,
  input wire logic hready,
  input wire uhid_pkg::uhid_word_t hrdata,
  input wire logic irq,
  input wire logic master_interrupt_switch
);
  import uhid_pkg::*;
  logic wph;
  logic rph;
  logic [11:0] ofs;
  wire take = hsel && htrans[1] && hready;
  wire dis = wph && ofs == `UHID_OFS_DISABLE;
  wire swr = wph && ofs == `UHID_OFS_SWRESET && hwdata[0];
  wire all_off = (hwdata & `UHID_SRC_MASK) == `UHID_SRC_MASK;
  // Data phase tracking, so checks align with the committing edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph <= 1'b0;
      rph <= 1'b0;
      ofs <= 12'h000;
    end else begin
      wph <= take && hwrite && hsize == `UHID_HSIZE_WORD;
      rph <= take && !hwrite;
      ofs <= haddr[11:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_MASTER_RST: assert property (
    $rose(hresetn) |-> master_interrupt_switch) else $error("master off");
  AST_IRQ_GATED: assert property (
    !master_interrupt_switch |-> !irq) else $error("irq while master off");
  AST_MASTER_OFF: assert property (
    dis && hwdata[31] |=> !master_interrupt_switch) else $error("master on");
  AST_MASTER_ZERO: assert property (
    dis && !hwdata[31] |=> $stable(master_interrupt_switch))
    else $error("master moved");
  AST_ALL_SRC_OFF: assert property (
    dis && all_off |=> !irq) else $error("irq with sources off");
  AST_SOFT_RESET: assert property (
    swr |=> master_interrupt_switch && !irq) else $error("soft reset");
  AST_RSVD_ZERO: assert property (
    (hrdata & 32'h7FFF_FF82) == `UHID_ZERO_WORD) else $error("reserved set");
  AST_IDLE_RDATA: assert property (
    !rph |-> hrdata == `UHID_ZERO_WORD) else $error("stray read data");
  cover property (dis);
  cover property (swr);
  cover property ($rose(irq));
endmodule : uhid_irq_disable_asserts

bind uhid_irq_disable uhid_irq_disable_asserts u_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsize(hsize),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .irq(irq),
  .master_interrupt_switch(master_interrupt_switch)
);

// ---- uhid_irq_disable_tb_top.sv ----
`timescale 1ns/1ps
`include "uhid_consts.svh"
module uhid_irq_disable_tb_top;
  import uhid_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = `UHID_HSIZE_WORD;
  logic [5:0] ev = 6'h00;
  uhid_word_t hwdata = `UHID_ZERO_WORD;
  uhid_word_t hrdata;
  uhid_word_t q;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic master_interrupt_switch;
  int bad_count = 0;
  int tests_run = 0;
  int b;
  wire hready = hreadyout;
  wire evt_sched_overrun = ev[0];
  wire evt_frame_begin = ev[1];
  wire evt_resume = ev[2];
  wire evt_fatal_fault = ev[3];
  wire evt_frame_wrap = ev[4];
  wire evt_port_change = ev[5];
  always #5 hclk = ~hclk;
  uhid_irq_disable u_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .evt_port_change(evt_port_change),
    .evt_frame_wrap(evt_frame_wrap),
    .evt_fatal_fault(evt_fatal_fault),
    .evt_resume(evt_resume),
    .evt_frame_begin(evt_frame_begin),
    .evt_sched_overrun(evt_sched_overrun),
    .irq(irq),
    .master_interrupt_switch(master_interrupt_switch)
  );
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task chk(input uhid_word_t got, input uhid_word_t exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task chkb(input logic got, input logic exp);
    chk({{31{1'b0}}, got}, {{31{1'b0}}, exp});
  endtask : chkb
  task rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      bad_count++;
      finish_test;
    end
  endtask : rdy
  // Master holds each phase until hready is seen high at an edge
  task xfer(input logic [11:0] a, input logic w, input uhid_word_t d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    q = hrdata;
    chkb(hresp, `UHID_HRESP_OKAY);
    #1;
  endtask : xfer
  task wr(input logic [11:0] a, input uhid_word_t d);
    xfer(a, 1'b1, d);
  endtask : wr
  task rd(input logic [11:0] a, input uhid_word_t e);
    xfer(a, 1'b0, `UHID_ZERO_WORD);
    chk(q, e);
  endtask : rd
  task pulse(input int k);
    @(posedge hclk);
    ev <= 6'h01 << k;
    @(posedge hclk);
    ev <= 6'h00;
    #1;
  endtask : pulse
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chkb(master_interrupt_switch, 1'b1);
    rd(`UHID_OFS_DISABLE, `UHID_ENABLE_RESET);
    $display("reset test done");
    for (int k = 0; k < 6; k++) begin
      b = (k == 0) ? 0 : k + 1;
      wr(`UHID_OFS_ENABLE, `UHID_ENABLE_MASK);
      wr(`UHID_OFS_DISABLE, `UHID_ZERO_WORD);
      rd(`UHID_OFS_DISABLE, `UHID_ENABLE_MASK);
      wr(`UHID_OFS_DISABLE, 32'h0000_0001 << b);
      rd(`UHID_OFS_DISABLE, `UHID_ENABLE_MASK & ~(32'h0000_0001 << b));
      pulse(k);
      chkb(irq, 1'b0);
      rd(`UHID_OFS_STATUS, 32'h0000_0001 << b);
      wr(`UHID_OFS_ENABLE, 32'h0000_0001 << b);
      chkb(irq, 1'b1);
      wr(`UHID_OFS_STATUS, `UHID_SRC_MASK);
      chkb(irq, 1'b0);
    end
    $display("source test done");
    pulse(2);
    chkb(irq, 1'b1);
    wr(`UHID_OFS_DISABLE, 32'h8000_0000);
    chkb(irq, 1'b0);
    rd(`UHID_OFS_DISABLE, `UHID_SRC_MASK);
    wr(`UHID_OFS_ENABLE, 32'h8000_0000);
    wr(`UHID_OFS_DISABLE, 32'h0000_0001);
    chkb(irq, 1'b1);
    wr(`UHID_OFS_DISABLE, 32'h8000_0000);
    wr(`UHID_OFS_SWRESET, 32'h0000_0001);
    chkb(master_interrupt_switch, 1'b1);
    rd(`UHID_OFS_ENABLE, `UHID_ENABLE_RESET);
    rd(`UHID_OFS_STATUS, `UHID_STATUS_RESET);
    $display("master test done");
    wr(12'h010, 32'hFFFF_FFFF);
    rd(12'h010, `UHID_ZERO_WORD);
    wr(`UHID_OFS_ENABLE, `UHID_ENABLE_MASK);
    rd(`UHID_OFS_ENABLE, `UHID_ENABLE_MASK);
    wr(`UHID_OFS_DISABLE, `UHID_SRC_MASK);
    rd(`UHID_OFS_DISABLE, 32'h8000_0000);
    wr(`UHID_OFS_ENABLE, `UHID_SRC_MASK);
    pulse(0);
    wr(`UHID_OFS_DISABLE, 32'h8000_0000);
    chkb(master_interrupt_switch, 1'b0);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chkb(master_interrupt_switch, 1'b1);
    rd(`UHID_OFS_ENABLE, `UHID_ENABLE_RESET);
    rd(`UHID_OFS_STATUS, `UHID_STATUS_RESET);
    $display("map and reset test done");
    finish_test;
  end
endmodule : uhid_irq_disable_tb_top
